// >>> design/keyboard_matrix_scanner.sv
// Keyboard matrix scanner with serial link, LEDs, beeper and reset chord
`timescale 1ns/1ps
module keyboard_matrix_scanner
	import kbd_scan_pkg::*;
#(
	parameter int unsigned BEEP_CYCLES = BEEP_CYC,
	parameter int unsigned DEB_COUNT   = DEB_SCANS
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [3:0]  scan_code,
	input  wire logic [7:0]  sense_input,
	input  wire logic        shift_left_n,
	input  wire logic        shift_right_n,
	input  wire logic        reset_key_n,
	input  wire logic        control_key_n,
	input  wire logic        terminal_to_kbd_serial,
	output logic             kbd_to_terminal_serial,
	output logic             kbd_ready_line_n,
	input  wire logic [2:0]  option_jumper,
	output logic             beeper_drive_bit,
	output logic      [6:0]  indicator,
	output logic             terminal_hw_reset_n
);
	// Modifier decode; all key inputs are active low
	// one shift input
	wire       shift_key_input   = ~shift_left_n | ~shift_right_n;
	wire       reset_key_input   = ~reset_key_n;
	wire       control_key_input = ~control_key_n;
	wire       chord             = ~shift_right_n & ~reset_key_n;
	wire [15:0] bit_len          = bit_cycles(option_jumper[1:0]);
	// Jumper 2 stretches the stop time to two bits for slow receivers
	wire       two_stop          = option_jumper[2];

	// Chord reset: held while the chord stands, then at least the minimum width
	logic [15:0] rst_cnt_q;
	logic        soft_rst_q;
	logic        term_rst_n_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_cnt_q    <= '0;
			soft_rst_q   <= 1'b0;
			term_rst_n_q <= 1'b1;
		end else begin
			if (chord)
				rst_cnt_q <= 16'(RST_MIN_CYC);
			else if (rst_cnt_q != '0)
				rst_cnt_q <= rst_cnt_q - 16'd1;
			soft_rst_q   <= chord || (rst_cnt_q != '0);
			term_rst_n_q <= !(chord || (rst_cnt_q != '0));
		end
	end
	assign terminal_hw_reset_n = term_rst_n_q;

	// Register file state
	logic [31:0] control_q;
	logic [31:0] rdata_q;
	logic        wait_q;
	logic [7:0]  last_key_q;
	logic [7:0]  last_cmd_q;
	wire         bus_req  = avs_read | avs_write;
	wire         wr_take  = avs_write & ~wait_q;
	wire         scan_en  = control_q[CTL_SCAN_EN];

	// Scanner
	scan_state_t sc_state_q;
	logic [3:0]  line_q;
	logic [15:0] settle_q;
	logic        found_q;
	logic [6:0]  cand_q;
	logic [6:0]  prev_q;
	logic        prev_ok_q;
	logic [3:0]  deb_q;
	logic        sent_q;
	logic        key_req_q;
	logic [7:0]  key_byte_q;

	// low sense bit means a closed key
	wire [7:0] closed = ~sense_input;
	logic [2:0] low_idx;
	always_comb begin
		low_idx = 3'd0;
		for (int i = SENSE_LINES - 1; i >= 0; i--)
			if (closed[i])
				low_idx = 3'(i);
	end
	wire       last_line = (line_q == 4'(SCAN_LINES - 1));
	wire [6:0] key_index = {line_q, low_idx};
	wire       tx_free;
	// modifiers shape the keycode; shift or control sets the top bit, control flips bit 6
	wire [7:0] key_code  = {control_key_input | shift_key_input,
		control_key_input ? (prev_q ^ 7'h40) : prev_q};

	// One line at a time: drive, settle, sample, step
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sc_state_q <= SC_SETTLE;
			line_q     <= '0;
			settle_q   <= '0;
			found_q    <= 1'b0;
			cand_q     <= '0;
			prev_q     <= '0;
			prev_ok_q  <= 1'b0;
			deb_q      <= '0;
			sent_q     <= 1'b0;
			key_req_q  <= 1'b0;
			key_byte_q <= '0;
		end else if (soft_rst_q || !scan_en) begin
			sc_state_q <= SC_SETTLE;
			line_q     <= '0;
			settle_q   <= '0;
			found_q    <= 1'b0;
			prev_ok_q  <= 1'b0;
			deb_q      <= '0;
			key_req_q  <= 1'b0;
		end else begin
			if (key_req_q && tx_free)
				key_req_q <= 1'b0;
			case (sc_state_q)
				SC_SETTLE: begin
					// line code held while sense settles
					if (settle_q == 16'(SETTLE_CYC - 1)) begin
						settle_q   <= '0;
						sc_state_q <= SC_SAMPLE;
					end else begin
						settle_q <= settle_q + 16'd1;
					end
				end
				SC_SAMPLE: begin
					if (!found_q && closed != 8'h00) begin
						found_q <= 1'b1;
						cand_q  <= key_index;
					end
					sc_state_q <= SC_NEXT;
				end
				SC_NEXT: begin
					sc_state_q <= SC_SETTLE;
					if (last_line) begin
						// full pass over all twelve lines
						line_q    <= '0;
						found_q   <= 1'b0;
						prev_q    <= cand_q;
						prev_ok_q <= found_q;
						if (!found_q) begin
							deb_q  <= '0;
							sent_q <= 1'b0;
						end else if (!prev_ok_q || cand_q != prev_q) begin
							deb_q  <= 4'd1;
							sent_q <= 1'b0;
						end else if (deb_q < 4'(DEB_COUNT)) begin
							deb_q <= deb_q + 4'd1;
						end else if (!sent_q && !key_req_q) begin
							sent_q     <= 1'b1;
							key_req_q  <= 1'b1;
							key_byte_q <= key_code;
						end
					end else begin
						line_q <= line_q + 4'd1;
					end
				end
				default: sc_state_q <= SC_SETTLE;
			endcase
		end
	end
	assign scan_code = line_q;

	// Transmitter
	ser_state_t tx_state_q;
	logic [15:0] tx_cnt_q;
	logic [2:0]  tx_bit_q;
	logic [7:0]  tx_sh_q;
	logic        tx_line_q;
	logic        tx_stop2_q;
	assign tx_free = (tx_state_q == SER_IDLE);
	wire tx_tick = (tx_cnt_q == bit_len - 16'd1);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx_state_q <= SER_IDLE;
			tx_cnt_q   <= '0;
			tx_bit_q   <= '0;
			tx_sh_q    <= '0;
			tx_line_q  <= 1'b1;
			tx_stop2_q <= 1'b0;
		end else if (soft_rst_q) begin
			tx_state_q <= SER_IDLE;
			tx_line_q  <= 1'b1;
			tx_cnt_q   <= '0;
		end else begin
			tx_cnt_q <= (tx_free || tx_tick) ? 16'd0 : tx_cnt_q + 16'd1;
			case (tx_state_q)
				SER_IDLE: begin
					if (key_req_q) begin
						tx_sh_q    <= key_byte_q;
						tx_line_q  <= 1'b0;
						tx_state_q <= SER_START;
					end
				end
				SER_START: begin
					if (tx_tick) begin
						tx_line_q  <= tx_sh_q[0];
						tx_bit_q   <= '0;
						tx_state_q <= SER_DATA;
					end
				end
				SER_DATA: begin
					if (tx_tick) begin
						if (tx_bit_q == 3'd7) begin
							tx_line_q  <= 1'b1;
							tx_stop2_q <= two_stop;
							tx_state_q <= SER_STOP;
						end else begin
							tx_line_q <= tx_sh_q[tx_bit_q + 3'd1];
							tx_bit_q  <= tx_bit_q + 3'd1;
						end
					end
				end
				SER_STOP: begin
					if (tx_tick) begin
						if (tx_stop2_q)
							tx_stop2_q <= 1'b0;
						else
							tx_state_q <= SER_IDLE;
					end
				end
				default: tx_state_q <= SER_IDLE;
			endcase
		end
	end
	assign kbd_to_terminal_serial = tx_line_q;

	// Receiver; inputs are synchronous, one flop suffices for the edge
	ser_state_t rx_state_q;
	logic [15:0] rx_cnt_q;
	logic [2:0]  rx_bit_q;
	logic [7:0]  rx_sh_q;
	logic        rx_prev_q;
	logic        rx_done_q;
	logic        cts_n_q;
	wire rx_start = rx_prev_q & ~terminal_to_kbd_serial;
	wire rx_mid   = (rx_cnt_q == {1'b0, bit_len[15:1]});
	wire rx_tick  = (rx_cnt_q == bit_len - 16'd1);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rx_state_q <= SER_IDLE;
			rx_cnt_q   <= '0;
			rx_bit_q   <= '0;
			rx_sh_q    <= '0;
			rx_prev_q  <= 1'b1;
			rx_done_q  <= 1'b0;
			cts_n_q    <= 1'b1;
		end else if (soft_rst_q) begin
			rx_state_q <= SER_IDLE;
			rx_prev_q  <= 1'b1;
			rx_done_q  <= 1'b0;
			cts_n_q    <= 1'b1;
		end else begin
			rx_prev_q <= terminal_to_kbd_serial;
			rx_done_q <= 1'b0;
			rx_cnt_q  <= (rx_state_q == SER_IDLE || rx_tick) ? 16'd0 : rx_cnt_q + 16'd1;
			cts_n_q   <= !(rx_state_q == SER_IDLE && !rx_start);
			case (rx_state_q)
				SER_IDLE: begin
					if (rx_start)
						rx_state_q <= SER_START;
				end
				SER_START: begin
					// A glitch shorter than half a bit is dropped
					if (rx_mid && terminal_to_kbd_serial)
						rx_state_q <= SER_IDLE;
					else if (rx_tick) begin
						rx_bit_q   <= '0;
						rx_state_q <= SER_DATA;
					end
				end
				SER_DATA: begin
					if (rx_mid)
						rx_sh_q <= {terminal_to_kbd_serial, rx_sh_q[7:1]};
					if (rx_tick) begin
						rx_bit_q <= rx_bit_q + 3'd1;
						if (rx_bit_q == 3'd7)
							rx_state_q <= SER_STOP;
					end
				end
				SER_STOP: begin
					// Frames with a low stop bit are discarded
					if (rx_mid) begin
						rx_done_q  <= terminal_to_kbd_serial;
						rx_state_q <= SER_IDLE;
					end
				end
				default: rx_state_q <= SER_IDLE;
			endcase
		end
	end
	assign kbd_ready_line_n = cts_n_q;

	// Command execution: top bit beeps, else low bits set the LEDs
	logic [6:0]  led_q;
	logic [31:0] beep_cnt_q;
	logic        beep_q;
	wire         cmd_beep = (rx_sh_q & CMD_BEEP_BIT) != 8'h00;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			led_q      <= '0;
			beep_cnt_q <= '0;
			beep_q     <= 1'b0;
		end else if (soft_rst_q) begin
			led_q      <= '0;
			beep_cnt_q <= '0;
			beep_q     <= 1'b0;
		end else begin
			if (rx_done_q && !cmd_beep)
				led_q <= rx_sh_q[6:0];
			if (rx_done_q && cmd_beep)
				beep_cnt_q <= BEEP_CYCLES;
			else if (beep_cnt_q != '0)
				beep_cnt_q <= beep_cnt_q - 32'd1;
			beep_q <= (beep_cnt_q != '0) && !control_q[CTL_MUTE];
		end
	end
	assign indicator        = led_q;
	assign beeper_drive_bit = beep_q;

	// Bus slave: one wait cycle, then the request is taken
	wire [31:0] status_word = {24'h0000_00, tx_free, rx_state_q == SER_IDLE, option_jumper,
		control_key_input, reset_key_input, shift_key_input};
	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address)
			OFS_STATUS:  rd_mux = status_word;
			OFS_KEYCODE: rd_mux = {24'h0000_00, last_key_q};
			OFS_CONTROL: rd_mux = control_q;
			OFS_COMMAND: rd_mux = {24'h0000_00, last_cmd_q};
			default:     rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wait_q     <= 1'b1;
			rdata_q    <= '0;
			control_q  <= CONTROL_RST;
			last_key_q <= '0;
			last_cmd_q <= '0;
		end else begin
			wait_q  <= !(bus_req && wait_q);
			rdata_q <= (avs_read && wait_q) ? rd_mux : rdata_q;
			if (wr_take && avs_address == OFS_CONTROL)
				control_q <= avs_writedata & 32'h0000_0003;
			if (key_req_q && tx_free)
				last_key_q <= key_byte_q;
			if (rx_done_q)
				last_cmd_q <= rx_sh_q;
		end
	end
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
endmodule

// >>> common/kbd_scan_pkg.sv
// Constants, types and helpers for the keyboard matrix scanner
// Function
// - One scan line at a time: 4-bit code, 1-of-16 decoded, line low.
// - Matrix is 12 scan lines by 8 sense lines, diodes stop phantoms.
// - After driving a scan line, sense lines are sampled before moving on.
// - Eight pulled-up sense lines read as one byte; low means closed.
// - Shift, reset, control keys are separate active-low inputs; shift and control modify keycodes.
// - Left and right shift are ORed into one shift input.
// - Right shift plus reset resets the controller and drives terminal reset low.
// - Reset key and control key are read on their own input bits.
// - A falling start bit on serial input starts character reception.
// - Keycodes go to the terminal as asynchronous serial data.
// - Active-low clear-to-send shows readiness for another character.
// - Three jumper inputs choose the serial communication options.
// - A dedicated output sounds the beeper.
// - Seven LED outputs change only on commands from the terminal; here the reset chord also clears them.
// - All control and bit timing derives from the controller clock.
package kbd_scan_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned SETTLE_NS      = 2000;
	localparam int unsigned SETTLE_CYC     = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned RST_MIN_US     = 100;
	localparam int unsigned RST_MIN_CYC    = RST_MIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BEEP_MS        = 100;
	localparam int unsigned BEEP_CYC       = BEEP_MS * (CLK_HZ / 1000);
	localparam int unsigned SCAN_LINES     = 12;
	localparam int unsigned SENSE_LINES    = 8;
	localparam int unsigned DEB_SCANS      = 4;
	// Bus map, byte offsets
	localparam logic [3:0]  OFS_STATUS     = 4'h0;
	localparam logic [3:0]  OFS_KEYCODE    = 4'h4;
	localparam logic [3:0]  OFS_CONTROL    = 4'h8;
	localparam logic [3:0]  OFS_COMMAND    = 4'hC;
	localparam logic [31:0] CONTROL_RST    = 32'h0000_0001;
	localparam int unsigned CTL_SCAN_EN    = 0;
	localparam int unsigned CTL_MUTE       = 1;
	localparam logic [7:0]  CMD_BEEP_BIT   = 8'h80;
	// Bit rates chosen by the two low jumpers
	localparam int unsigned BAUD_0         = 19200;
	localparam int unsigned BAUD_1         = 9600;
	localparam int unsigned BAUD_2         = 4800;
	localparam int unsigned BAUD_3         = 1200;

	typedef enum logic [1:0] {
		SC_SETTLE = 2'b00,
		SC_SAMPLE = 2'b01,
		SC_NEXT   = 2'b11
	} scan_state_t;

	typedef enum logic [1:0] {
		SER_IDLE  = 2'b00,
		SER_START = 2'b01,
		SER_DATA  = 2'b11,
		SER_STOP  = 2'b10
	} ser_state_t;

	// Cycles per serial bit for a jumper setting
	function automatic logic [15:0] bit_cycles(input logic [1:0] sel);
		case (sel)
			2'd0:    bit_cycles = 16'(CLK_HZ / BAUD_0);
			2'd1:    bit_cycles = 16'(CLK_HZ / BAUD_1);
			2'd2:    bit_cycles = 16'(CLK_HZ / BAUD_2);
			default: bit_cycles = 16'(CLK_HZ / BAUD_3);
		endcase
	endfunction
endpackage

// >>> testbench/kbd_scan_chk.sv
// Port-level assertions for the keyboard scanner
`timescale 1ns/1ps
module kbd_scan_chk
	import kbd_scan_pkg::*;
#(
	parameter int unsigned BEEP_CYCLES = BEEP_CYC,
	parameter int unsigned DEB_COUNT   = DEB_SCANS
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [3:0]  scan_code,
	input wire logic [7:0]  sense_input,
	input wire logic        shift_left_n,
	input wire logic        shift_right_n,
	input wire logic        reset_key_n,
	input wire logic        control_key_n,
	input wire logic        terminal_to_kbd_serial,
	input wire logic        kbd_to_terminal_serial,
	input wire logic        kbd_ready_line_n,
	input wire logic [2:0]  option_jumper,
	input wire logic        beeper_drive_bit,
	input wire logic [6:0]  indicator,
	input wire logic        terminal_hw_reset_n
);
	logic [3:0]  scan_q;
	logic [7:0]  line_q, line_d;
	logic [11:0] rel_q, rel_d;
	logic [15:0] beep_q, beep_d;
	logic        chord;
	// Raw chord; the design sees it a little later, so counts only err long
	assign chord = !shift_right_n && !reset_key_n;
	assign line_d = (scan_code != scan_q) ? 8'h00 : line_q + {7'h00, line_q != 8'hFF};
	assign rel_d = (chord || terminal_hw_reset_n) ? 12'h000 : rel_q + {11'h000, rel_q != 12'hFFF};
	assign beep_d = beeper_drive_bit ? beep_q + 16'h0001 : 16'h0000;
	// History and cycle counters
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			scan_q <= 4'h0;
			line_q <= 8'h00;
			rel_q  <= 12'h000;
			beep_q <= 16'h0000;
		end else begin
			scan_q <= scan_code;
			line_q <= line_d;
			rel_q  <= rel_d;
			beep_q <= beep_d;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	scan_range_a: assert property (scan_code < 4'hC)
		else $error("scan code beyond last line");
	// A halt jumps back to line zero at once, so only steps to later lines count
	line_settle_a: assert property (scan_code != scan_q && scan_code != 4'h0 &&
		terminal_hw_reset_n |-> line_q >= 8'(SETTLE_CYC))
		else $error("scan line left before settling");
	chord_react_a: assert property (chord |-> ##[1:3] !terminal_hw_reset_n)
		else $error("chord gave no terminal reset");
	reset_width_a: assert property ($rose(terminal_hw_reset_n) |-> rel_q >= 12'(RST_MIN_CYC - 1))
		else $error("terminal reset too short");
	chord_clear_a: assert property (!terminal_hw_reset_n ##1 !terminal_hw_reset_n |->
		indicator == 7'h00 && !beeper_drive_bit && kbd_ready_line_n)
		else $error("chord left state uncleared");
	ready_drop_a: assert property ($fell(terminal_to_kbd_serial) && !kbd_ready_line_n |-> ##[1:4] kbd_ready_line_n)
		else $error("ready stayed low during frame");
	led_cause_a: assert property ($changed(indicator) && terminal_hw_reset_n |->
		$past(kbd_ready_line_n) || $past(kbd_ready_line_n, 2))
		else $error("indicator changed without a frame");
	beep_len_a: assert property ($fell(beeper_drive_bit) && terminal_hw_reset_n |-> beep_q == 16'(BEEP_CYCLES))
		else $error("beep length wrong");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus wait state wrong");
	cover property (chord ##1 !terminal_hw_reset_n);
	cover property ($fell(beeper_drive_bit));
	cover property (scan_code == 4'hB);
endmodule
bind keyboard_matrix_scanner kbd_scan_chk #(.BEEP_CYCLES(BEEP_CYCLES), .DEB_COUNT(DEB_COUNT)) i_chk (
	.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .scan_code(scan_code), .sense_input(sense_input),
	.shift_left_n(shift_left_n), .shift_right_n(shift_right_n), .reset_key_n(reset_key_n),
	.control_key_n(control_key_n), .terminal_to_kbd_serial(terminal_to_kbd_serial),
	.kbd_to_terminal_serial(kbd_to_terminal_serial), .kbd_ready_line_n(kbd_ready_line_n),
	.option_jumper(option_jumper), .beeper_drive_bit(beeper_drive_bit),
	.indicator(indicator), .terminal_hw_reset_n(terminal_hw_reset_n)
);

// >>> testbench/term_model.sv
// Terminal-side partner: keyboard UART and reset pulse shaping
`timescale 1ns/1ps
module term_model #(
	parameter int BIT_CYC   = 1302,
	parameter int PULSE_CYC = 2500
) (
	input  wire logic sys_clk,
	input  wire logic kbd_to_terminal_serial,
	input  wire logic kbd_ready_line_n,
	input  wire logic terminal_hw_reset_n,
	output logic      terminal_to_kbd_serial,
	output logic      term_reset_n
);
	logic [7:0]  rx_q [$];
	logic [7:0]  rx_byte;
	logic [11:0] pulse_q = 12'h000;
	int          frame_err = 0;
	always @(posedge sys_clk) begin
		if (!terminal_hw_reset_n) pulse_q <= 12'(PULSE_CYC);
		else if (pulse_q != 12'h000) pulse_q <= pulse_q - 12'h001;
	end
	assign term_reset_n = terminal_hw_reset_n && pulse_q == 12'h000;
	// mid-bit sampling, stop must be high
	initial begin
		forever begin
			@(negedge kbd_to_terminal_serial);
			repeat (BIT_CYC / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge sys_clk);
				rx_byte[i] = kbd_to_terminal_serial;
			end
			repeat (BIT_CYC) @(posedge sys_clk);
			if (kbd_to_terminal_serial) rx_q.push_back(rx_byte);
			else frame_err++;
		end
	end
	initial terminal_to_kbd_serial = 1'b1;
	// no start while not clear to send, unless 50000 cycles pass first
	task automatic send(input logic [7:0] b);
		int w;
		w = 0;
		while (kbd_ready_line_n !== 1'b0 && w < 50000) begin
			@(posedge sys_clk);
			w++;
		end
		// start, data from bit 0, stop
		terminal_to_kbd_serial <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk);
			terminal_to_kbd_serial <= b[i];
		end
		repeat (BIT_CYC) @(posedge sys_clk);
		terminal_to_kbd_serial <= 1'b1;
		repeat (BIT_CYC + 4) @(posedge sys_clk);
	endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the keyboard scanner
`timescale 1ns/1ps
module tb_top;
	import kbd_scan_pkg::*;
	typedef struct packed {logic [3:0] ln; logic [2:0] bt; logic [1:0] mods; logic [7:0] code;} key_row_t;
	logic        sys_clk, nrst, avs_read, avs_write, wait_rq, key_on;
	logic        shift_left_n, shift_right_n, reset_key_n, control_key_n;
	logic        t2k, k2t, ready_n, beeper, hw_rst_n, term_rst_n;
	logic [3:0]  avs_address, scan_code, key_line;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0]  sense_input;
	logic [6:0]  indicator;
	logic [2:0]  option_jumper, key_bit;
	int          bad_count, checks_done, beep_len;
	// Plain, shift at top line, control at line zero
	key_row_t    rows [3] = '{'{4'h2, 3'h3, 2'h0, 8'h13}, '{4'hB, 3'h7, 2'h2, 8'hDF},
		'{4'h0, 3'h0, 2'h1, 8'hC0}};
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// closed key pulls its sense line low
	always @(posedge sys_clk) begin
		sense_input <= (key_on && scan_code == key_line) ? ~(8'h01 << key_bit) : 8'hFF;
		if (beeper) beep_len++;
	end
	keyboard_matrix_scanner #(.BEEP_CYCLES(200), .DEB_COUNT(2)) i_dut (
		.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(wait_rq), .scan_code(scan_code), .sense_input(sense_input),
		.shift_left_n(shift_left_n), .shift_right_n(shift_right_n), .reset_key_n(reset_key_n),
		.control_key_n(control_key_n), .terminal_to_kbd_serial(t2k),
		.kbd_to_terminal_serial(k2t), .kbd_ready_line_n(ready_n), .option_jumper(option_jumper),
		.beeper_drive_bit(beeper), .indicator(indicator), .terminal_hw_reset_n(hw_rst_n));
	term_model #(.BIT_CYC(CLK_HZ / BAUD_0), .PULSE_CYC(RST_MIN_CYC)) i_term (
		.sys_clk(sys_clk), .kbd_to_terminal_serial(k2t), .kbd_ready_line_n(ready_n),
		.terminal_hw_reset_n(hw_rst_n), .terminal_to_kbd_serial(t2k), .term_reset_n(term_rst_n));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Held until waitrequest is sampled low, released right after that edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
		@(posedge sys_clk);
		while (wait_rq !== 1'b0) begin
			@(posedge sys_clk);
			n++;
		end
		rd = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
		chk("bus wait cycles", n, 1);
		@(posedge sys_clk);
	endtask
	task automatic status_case(input logic [3:0] keys_n, input logic [2:0] jmp, input logic [5:0] exp);
		{shift_left_n, shift_right_n, reset_key_n, control_key_n} <= keys_n;
		option_jumper <= jmp;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status", rd[5:0], exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Longest path is about 82k cycles
	initial begin
		repeat (100000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{nrst, avs_read, avs_write, key_on, avs_address, key_line, key_bit} = '0;
		{shift_left_n, shift_right_n, reset_key_n, control_key_n} = 4'hF;
		{avs_writedata, option_jumper, sense_input} = {35'h0, 8'hFF};
		{bad_count, checks_done, beep_len} = '0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("reset outputs", {hw_rst_n, k2t, ready_n, beeper, indicator}, 11'h600);
		bus(1'b0, OFS_CONTROL, 32'h0000_0000);
		chk("control reset", rd, CONTROL_RST);
		bus(1'b0, 4'h2, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		bus(1'b1, OFS_KEYCODE, 32'h0000_00AA);
		bus(1'b0, OFS_KEYCODE, 32'h0000_0000);
		chk("keycode ro", rd, 32'h0000_0000);
		$display("test reset and bus done");
		for (int r = 0; r < 3; r++) begin
			{key_line, key_bit, key_on} <= {rows[r].ln, rows[r].bt, 1'b1};
			option_jumper <= (r == 2) ? 3'h4 : 3'h0;
			{shift_left_n, control_key_n} <= ~rows[r].mods;
			for (int n = 0; n < 40000 && i_term.rx_q.size() == 0; n++) @(posedge sys_clk);
			chk("sent code", i_term.rx_q.size() > 0 ? i_term.rx_q.pop_front() : 8'h00, rows[r].code);
			bus(1'b0, OFS_KEYCODE, 32'h0000_0000);
			chk("keycode reg", rd, rows[r].code);
			{key_on, shift_left_n, control_key_n} <= 3'h3;
			// Only the last row has a second stop bit, which keeps the sender busy here
			repeat (1000) @(posedge sys_clk);
			bus(1'b0, OFS_STATUS, 32'h0000_0000);
			chk("tx idle", rd[7], r != 2);
			repeat (300) @(posedge sys_clk);
			$display("test key row %0d done", r);
		end
		// one pass is too short to report
		{key_line, key_bit, key_on} <= {4'h5, 3'h1, 1'b1};
		repeat (624) @(posedge sys_clk);
		key_on <= 1'b0;
		repeat (4000) @(posedge sys_clk);
		chk("glitch or repeat", i_term.rx_q.size(), 0);
		bus(1'b0, OFS_KEYCODE, 32'h0000_0000);
		chk("glitch code", rd, 32'h0000_00C0);
		chk("frame errors", i_term.frame_err, 0);
		status_case(4'hB, 3'h0, 6'h01);
		status_case(4'h7, 3'h0, 6'h01);
		status_case(4'hD, 3'h5, 6'h2A);
		status_case(4'hE, 3'h2, 6'h14);
		status_case(4'hF, 3'h0, 6'h00);
		$display("test keys and status done");
		i_term.send(8'h55);
		chk("led", indicator, 7'h55);
		bus(1'b0, OFS_COMMAND, 32'h0000_0000);
		chk("command reg", rd, 32'h0000_0055);
		beep_len = 0;
		i_term.send(8'h80);
		chk("beep length", beep_len, 200);
		chk("led kept", indicator, 7'h55);
		$display("test commands done");
		bus(1'b1, OFS_CONTROL, 32'hFFFF_FFFE);
		repeat (700) @(posedge sys_clk);
		chk("halted line", scan_code, 4'h0);
		{shift_right_n, reset_key_n} <= 2'h0;
		repeat (10) @(posedge sys_clk);
		chk("chord", {hw_rst_n, term_rst_n, indicator}, 9'h000);
		{shift_right_n, reset_key_n} <= 2'h3;
		repeat (RST_MIN_CYC - 50) @(posedge sys_clk);
		chk("chord hold", hw_rst_n, 1'b0);
		repeat (100) @(posedge sys_clk);
		chk("chord end", {hw_rst_n, term_rst_n}, 2'h2);
		bus(1'b0, OFS_CONTROL, 32'h0000_0000);
		chk("control kept", rd, 32'h0000_0002);
		$display("test chord done");
		report_and_stop();
	end
endmodule
